//--- rtl/deser_out_defs.svh
/*
  timing counts, range codes and word field positions for the output and
  lock control of the deserializer; included by the rtl modules and the monitor.
*/
`ifndef DESER_OUT_DEFS_SVH
`define DESER_OUT_DEFS_SVH

`define CLK_PERIOD_NS 20
`define REF_LOCK_MAX 16385
`define LOSS_WINDOW 1048576
`define STAGGER_NS 1
`define STAGGER_RAW ((`STAGGER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAGGER_CYC (`STAGGER_RAW < 1 ? 1 : `STAGGER_RAW)
`define STRETCH_CYC 4
`define RANGE_LOW 2'h2
`define RANGE_HIGH 2'h3
`define WORD_BITS 20
`define EN0_POS 0
`define PIX_LSB 2
`define CTL_LSB 1
`define PIX_BITS 18
`define CTL_BITS 9
`define GROUP_BITS 6

`endif

//--- rtl/deser_out_pkg.sv
/*
  types shared by the output and lock control.
  assumes nothing beyond the defs header.
*/
package deser_out_pkg;
  typedef enum logic [1:0] {ST_SLEEP, ST_REF_LOCK, ST_SEARCH, ST_LOCKED}
    lock_state_e;
  typedef logic [1:0] range_t;
endpackage

//--- rtl/pixel_group_reg.sv
/*
  one six-bit pixel output group with its own load delay.
  assumes load pulses come from the same clock and reset already synced.
*/
`timescale 1ns/1ns
`include "deser_out_defs.svh"
module pixel_group_reg #(
  parameter int WIDTH = `GROUP_BITS,
  parameter int DELAY = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] data_r;
  logic load_d;
  logic [WIDTH-1:0] held_d;

  generate
    if (DELAY == 0) begin : g_now
      assign load_d = load;
      assign held_d = data_in;
    end else begin : g_late
      logic [DELAY-1:0] ld_pipe_r;
      logic [WIDTH-1:0] dat_pipe_r [DELAY];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ld_pipe_r <= '0;
          for (int i = 0; i < DELAY; i++) begin
            dat_pipe_r[i] <= '0;
          end
        end else begin
          ld_pipe_r[0] <= load & ~clear;
          dat_pipe_r[0] <= data_in;
          for (int i = 1; i < DELAY; i++) begin
            ld_pipe_r[i] <= ld_pipe_r[i-1] & ~clear;
            dat_pipe_r[i] <= dat_pipe_r[i-1];
          end
        end
      end
      assign load_d = ld_pipe_r[DELAY-1];
      assign held_d = dat_pipe_r[DELAY-1];
    end
  endgenerate

  // hold last value unless cleared or loaded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
    end else if (clear) begin
      data_r <= '0;
    end else if (load_d) begin
      data_r <= held_d;
    end
  end

  assign data_out = data_r;
endmodule

//--- rtl/deser_output_lock_control.sv
/*
  output side of the deserializer: phase selection of pixel or control
  data, range and edge-rate select, output clock choice and latch edge,
  staggered pixel groups, output enable and lock supervision.
  assumes a front end on clk delivers decoded 20-bit words with a strobe,
  a video/control mark and a transition-word flag; pins are asynchronous.
*/
// Behaviour
// - range 10 is 7-15 MHz slow edges, 11 is 15-35 MHz fast, 00/01 unused
// - slow transitions in low range, fast transitions in high range
// - no transition word in 2^20 output clocks drops lock, outputs low
// - after lock loss output clock follows reference, keep searching
// - output drive enable governs every output together for busing
// - latch select high means downstream captures on output clock rise
// - latch select low means downstream captures on output clock fall
// - pixel outputs switch as three staggered groups of six
// - control outputs update only in control phase
// - phase flag high while video words drive pixel outputs
// - phase flag low while control words drive control outputs
// - group not updated in current phase holds last value
// - after sleep release lock to reference within 16385 cycles, then search
// - transition word sets lock low, switches to recovered clock, stretched
// - control bits 0-4 voted two of three, bits 5-8 taken directly
// - serial input idle gives outputs low, lock high, clock from reference
`timescale 1ns/1ns
`include "deser_out_defs.svh"
module deser_output_lock_control
  import deser_out_pkg::*;
#(
  parameter int REF_LOCK_MAX = `REF_LOCK_MAX,
  parameter int LOSS_WINDOW = `LOSS_WINDOW,
  parameter int STRETCH_CYC = `STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_n,
  input wire deser_out_pkg::range_t freq_range_select,
  input wire logic output_drive_enable,
  input wire logic latch_rising,
  input wire logic local_reference_clock,
  input wire logic recovered_clock,
  input wire logic link_active,
  input wire logic word_valid,
  input wire logic [`WORD_BITS-1:0] word_data,
  input wire logic word_video,
  input wire logic word_transition,
  output logic [`PIX_BITS-1:0] pixel_data_out,
  output logic [`CTL_BITS-1:0] control_word_out,
  output logic video_phase_flag,
  output logic lock_n,
  output logic pclk_out,
  output logic outputs_oe,
  output logic slew_fast,
  output logic range_valid
);
  import deser_out_pkg::*;

  localparam int NPIN = 8;
  localparam int STG = `STAGGER_CYC;

  logic rst_s1_r, rst_s2_r;
  logic [NPIN-1:0] pin_s1_r, pin_s2_r;
  logic sleep_s, oe_s, latch_s, ref_s, rec_s, act_s;
  range_t range_s;
  logic ref_d_r, pclk_d_r;
  lock_state_e state_r;
  logic [$clog2(REF_LOCK_MAX+1)-1:0] ref_cnt_r;
  logic [$clog2(LOSS_WINDOW+1)-1:0] loss_cnt_r;
  logic [$clog2(STRETCH_CYC+1)-1:0] stretch_r;
  logic locked, locked_d_r, clear_out, pclk_r, lock_n_r, phase_r;
  logic pix_load, ctl_load;
  logic [`PIX_BITS-1:0] pix_dec;
  logic [`CTL_BITS-1:0] ctl_dec, ctl_r;
  logic [`WORD_BITS-2:0] ctl_raw;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {freq_range_select, output_drive_enable, latch_rising,
                   local_reference_clock, recovered_clock, link_active,
                   sleep_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {range_s, oe_s, latch_s, ref_s, rec_s, act_s, sleep_s} = pin_s2_r;

  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ref_d_r <= 1'b0;
      pclk_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_s;
      pclk_d_r <= pclk_r;
    end
  end

  // lock supervision
  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= ST_SLEEP;
      ref_cnt_r <= '0;
      loss_cnt_r <= '0;
    end else if (!sleep_s) begin
      state_r <= ST_SLEEP;
      ref_cnt_r <= '0;
      loss_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_SLEEP: begin
          state_r <= ST_REF_LOCK;
          ref_cnt_r <= '0;
        end
        ST_REF_LOCK: begin
          if (ref_s && !ref_d_r) begin
            ref_cnt_r <= ref_cnt_r + 1'b1;
          end
          if (ref_cnt_r == ($bits(ref_cnt_r))'(REF_LOCK_MAX)) begin
            state_r <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          loss_cnt_r <= '0;
          if (act_s && word_valid && word_transition) begin
            state_r <= ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          if (!act_s) begin
            state_r <= ST_SEARCH;
          end else if (word_valid && word_transition) begin
            loss_cnt_r <= '0;
          end else if (loss_cnt_r ==
                       ($bits(loss_cnt_r))'(LOSS_WINDOW)) begin
            state_r <= ST_SEARCH;
          end else if (pclk_r && !pclk_d_r) begin
            loss_cnt_r <= loss_cnt_r + 1'b1;
          end
        end
        default: state_r <= ST_SLEEP;
      endcase
    end
  end

  assign locked = (state_r == ST_LOCKED);
  assign clear_out = !locked;

  // output clock: reference or recovered, stretched at changeover
  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      locked_d_r <= 1'b0;
      stretch_r <= '0;
      pclk_r <= 1'b0;
      lock_n_r <= 1'b1;
    end else begin
      locked_d_r <= locked;
      lock_n_r <= !locked;
      if (locked != locked_d_r) begin
        stretch_r <= ($bits(stretch_r))'(STRETCH_CYC);
      end else if (stretch_r != '0) begin
        stretch_r <= stretch_r - 1'b1;
      end
      if (stretch_r != '0) begin
        pclk_r <= pclk_r;
      end else if (locked) begin
        pclk_r <= rec_s ^ latch_s;
      end else begin
        pclk_r <= ref_s;
      end
    end
  end

  // word decoding: symbols inverted when EN0 set
  assign pix_dec = word_data[`PIX_LSB +: `PIX_BITS] ^
                   {`PIX_BITS{word_data[`EN0_POS]}};
  assign ctl_raw = word_data[`CTL_LSB +: `WORD_BITS-1] ^
                   {(`WORD_BITS-1){word_data[`EN0_POS]}};
  always_comb begin
    ctl_dec = '0;
    for (int i = 0; i < 5; i++) begin
      ctl_dec[i] = (ctl_raw[3*i] & ctl_raw[3*i+1]) |
                   (ctl_raw[3*i] & ctl_raw[3*i+2]) |
                   (ctl_raw[3*i+1] & ctl_raw[3*i+2]);
    end
    ctl_dec[8:5] = ctl_raw[18:15];
  end

  assign pix_load = locked && word_valid && word_video;
  assign ctl_load = locked && word_valid && !word_video;

  // staggered pixel groups
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pix
      pixel_group_reg #(.WIDTH(`GROUP_BITS), .DELAY(g * STG)) u_grp (
        .clk(clk),
        .rst_n(rst_s2_r),
        .clear(clear_out),
        .load(pix_load),
        .data_in(pix_dec[g*`GROUP_BITS +: `GROUP_BITS]),
        .data_out(pixel_data_out[g*`GROUP_BITS +: `GROUP_BITS])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ctl_r <= '0;
      phase_r <= 1'b0;
    end else if (clear_out) begin
      ctl_r <= '0;
      phase_r <= 1'b0;
    end else begin
      if (ctl_load) begin
        ctl_r <= ctl_dec;
      end
      if (word_valid) begin
        phase_r <= word_video;
      end
    end
  end

  assign control_word_out = ctl_r;
  assign video_phase_flag = phase_r;
  assign lock_n = lock_n_r;
  assign pclk_out = pclk_r;
  assign outputs_oe = oe_s && sleep_s;
  assign slew_fast = (range_s == `RANGE_HIGH);
  assign range_valid = (range_s == `RANGE_LOW) || slew_fast;
endmodule

//--- sim/deser_out_monitor.sv
/*
  checker for the deserializer output and lock control.
  bound to the top module and sees its ports only.
*/
`timescale 1ns/1ns
`include "deser_out_defs.svh"
module deser_out_monitor
  import deser_out_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_n,
  input wire deser_out_pkg::range_t freq_range_select,
  input wire logic output_drive_enable,
  input wire logic link_active,
  input wire logic word_valid,
  input wire logic [`WORD_BITS-1:0] word_data,
  input wire logic word_video,
  input wire logic [`PIX_BITS-1:0] pixel_data_out,
  input wire logic [`CTL_BITS-1:0] control_word_out,
  input wire logic video_phase_flag,
  input wire logic lock_n,
  input wire logic outputs_oe,
  input wire logic slew_fast,
  input wire logic range_valid
);
  logic [3:0] up_r;
  logic go;
  logic [5:0] inv;
  assign go = up_r[3];
  assign inv = {6{word_data[0]}};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 4'h0;
    end else if (!go) begin
      up_r <= up_r + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_on: assert property (
    (go && output_drive_enable && sleep_n) [*4] |-> outputs_oe)
    else $error("outputs not driven");
  a_oe_off: assert property (
    (go && !output_drive_enable) [*4] |-> !outputs_oe)
    else $error("outputs driven while disabled");
  a_range_fast: assert property (
    (go && freq_range_select == `RANGE_HIGH) [*4] |-> slew_fast && range_valid)
    else $error("high range not fast");
  a_range_slow: assert property (
    (go && freq_range_select == `RANGE_LOW) [*4] |-> !slew_fast && range_valid)
    else $error("low range not slow");
  a_idle_unlock: assert property (
    (go && !link_active) [*6] |-> lock_n)
    else $error("idle link still locked");
  a_unlock_clear: assert property (
    lock_n |-> pixel_data_out == '0 && control_word_out == '0 &&
    !video_phase_flag) else $error("outputs not low while unlocked");
  a_phase_kind: assert property (
    word_valid && !lock_n |=> video_phase_flag == $past(word_video))
    else $error("phase flag wrong");
  a_ctl_hold: assert property (
    word_valid && word_video && !lock_n |=> $stable(control_word_out))
    else $error("control changed in video phase");
  a_pix_stagger: assert property (
    word_valid && word_video && !lock_n |=>
    pixel_data_out[5:0] == ($past(word_data[7:2]) ^ $past(inv)) ##2
    pixel_data_out[17:12] == ($past(word_data[19:14], 3) ^ $past(inv, 3)))
    else $error("pixel group timing wrong");
  c_lock: cover property ($fell(lock_n));
  c_video: cover property (word_valid && word_video && !lock_n);
  c_unlock: cover property ($rose(lock_n));
endmodule
bind deser_output_lock_control deser_out_monitor u_mon (.*);

//--- sim/ser_link_model.sv
/*
  serializer side model presenting decoded words on request.
  assumes requests driven on clk by non-blocking assignment.
*/
`timescale 1ns/1ns
module ser_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_on,
  input wire logic req,
  input wire logic req_video,
  input wire logic req_trans,
  input wire logic [19:0] req_data,
  output logic link_active,
  output logic recovered_clock,
  output logic word_valid,
  output logic [19:0] word_data,
  output logic word_video,
  output logic word_transition
);
  logic [1:0] ph;
  always @(posedge clk) begin
    if (!rst_n) begin
      ph <= 2'h0;
      {link_active, recovered_clock, word_valid, word_video} <= 4'h0;
      word_transition <= 1'b0;
      word_data <= 20'h00000;
    end else begin
      link_active <= link_on;
      ph <= ph + 2'h1;
      // recovered clock stands still while the link is idle
      recovered_clock <= link_on & ph[1];
      word_valid <= req;
      word_video <= req & req_video;
      word_transition <= req & req_trans;
      // idle data keeps changing so a stale word never looks valid
      word_data <= req ? req_data : ~word_data;
    end
  end
endmodule

//--- sim/deser_output_lock_control_tb_top.sv
/*
  self-checking bench for the output and lock control.
  assumes the serializer model stands in for the link front end.
*/
`timescale 1ns/1ns
module deser_output_lock_control_tb_top;
  import deser_out_pkg::*;
  logic clk, rst_n, sleep_n, output_drive_enable, latch_rising;
  logic local_reference_clock, recovered_clock, link_active, link_on;
  logic word_valid, word_video, word_transition, req, req_video, req_trans;
  logic [19:0] word_data, req_data;
  logic [17:0] pixel_data_out;
  logic [8:0] control_word_out;
  logic video_phase_flag, lock_n, pclk_out, outputs_oe, slew_fast;
  logic range_valid;
  range_t freq_range_select;
  logic [1:0] ref_cnt = 2'h0;
  logic [2:0] ref_hist = 3'h0;
  logic [2:0] rec_hist = 3'h0;
  int num_errors = 0;
  int cmp_count = 0;
  deser_output_lock_control #(.REF_LOCK_MAX(8), .LOSS_WINDOW(16),
    .STRETCH_CYC(2)) uut (.*);
  ser_link_model peer (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    local_reference_clock <= ref_cnt[1];
  end
  // clock pins as seen three cycles back, the output clock latency
  always @(negedge clk) begin
    ref_hist <= {ref_hist[1:0], local_reference_clock};
    rec_hist <= {rec_hist[1:0], recovered_clock};
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic v, input logic t, input logic [19:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_video <= v;
    req_trans <= t;
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic t_clk(input logic lk);
    for (int i = 0; i < 8; i++) begin
      tick(1);
      if (lk) begin
        chk(pclk_out, rec_hist[2] ^ latch_rising);
      end else begin
        chk(pclk_out, ref_hist[2]);
      end
    end
  endtask
  task automatic t_range;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      freq_range_select <= i[1:0];
      tick(4);
      chk(slew_fast, i == 3);
      chk(range_valid, i > 1);
    end
  endtask
  task automatic t_oe;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      output_drive_enable <= i[0];
      tick(4);
      chk(outputs_oe, i[0]);
    end
  endtask
  task automatic t_lock;
    @(posedge clk);
    sleep_n <= 1'b1;
    link_on <= 1'b1;
    t_oe();
    tick(50);
    chk(lock_n, 1'b1);
    send(1'b0, 1'b1, 20'h0);
    tick(3);
    chk(lock_n, 1'b0);
    tick(3);
    t_clk(1'b1);
  endtask
  task automatic t_ctl;
    send(1'b0, 1'b0, 20'hE585E);
    tick(2);
    chk(control_word_out, 9'h1CB);
    chk(video_phase_flag, 1'b0);
    chk(pixel_data_out, 18'h0);
  endtask
  task automatic t_video;
    send(1'b1, 1'b0, {18'h2A5C3, 2'h0});
    tick(4);
    chk(pixel_data_out, 18'h2A5C3);
    chk(video_phase_flag, 1'b1);
    chk(control_word_out, 9'h1CB);
    send(1'b1, 1'b0, {~18'h15A3C, 2'h1});
    tick(4);
    chk(pixel_data_out, 18'h15A3C);
    send(1'b0, 1'b0, 20'h63C35);
    tick(2);
    chk(control_word_out, 9'h135);
    chk(pixel_data_out, 18'h15A3C);
    chk(video_phase_flag, 1'b0);
  endtask
  task automatic t_loss;
    tick(100);
    chk(lock_n, 1'b1);
    chk(control_word_out, 9'h0);
    t_clk(1'b0);
    @(posedge clk);
    latch_rising <= 1'b1;
    send(1'b0, 1'b1, 20'h0);
    tick(3);
    chk(lock_n, 1'b0);
    tick(3);
    t_clk(1'b1);
    @(posedge clk);
    link_on <= 1'b0;
    tick(8);
    chk(lock_n, 1'b1);
    chk(pixel_data_out, 18'h0);
  endtask
  task automatic results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    tick(3000);
    num_errors++;
    results();
  end
  initial begin
    {rst_n, sleep_n, latch_rising, link_on, req, req_video} = '0;
    req_trans = 1'b0;
    output_drive_enable = 1'b1;
    freq_range_select = 2'h3;
    req_data = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_range();
    t_lock();
    t_ctl();
    t_video();
    t_loss();
    results();
  end
endmodule
